// [common/arc_pkg.sv]
// package: constants and types of the analog reference control block
package arc_pkg;
    localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'hC9;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;
    localparam logic [7:0] RST_REGULATOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_REFERENCE_CONTROL = 8'h00;
    localparam logic [7:0] REF_CTRL_IMPL_MASK = 8'h9F;
    localparam int BIT_REF_BUFFER_GAIN_SEL = 7;
    localparam int BIT_REGULATOR_REF_OVERRIDE = 4;
    localparam int BIT_REF_SOURCE_SEL = 3;
    localparam int BIT_TEMP_SENSOR_EN = 2;
    localparam int BIT_ANALOG_BIAS_EN = 1;
    localparam int BIT_REF_BUFFER_DRIVE_EN = 0;
    localparam int BIT_STOP_POWER_CFG = 3;
    localparam int NUM_RESET_SRC = 4;
    typedef enum logic [1:0] {
        ARC_SRC_VREF_PIN,
        ARC_SRC_VDD,
        ARC_SRC_REGULATOR
    } arc_ref_src_t;
endpackage

// [common/arc_cfg_if.sv]
// interface: control register contents passed from storage to logic
`timescale 1ns/100ps
interface arc_cfg_if;
    logic [7:0] reference_control;
    logic [7:0] regulator_control;
    modport owner (output reference_control, output regulator_control);
    modport user (input reference_control, input regulator_control);
endinterface

// [rtl/arc_regs.sv]
// module: storage of the two control registers
`timescale 1ns/100ps
module arc_regs (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    arc_cfg_if.owner cfg
);
    import arc_pkg::*;

    logic [7:0] ref_q;
    logic [7:0] reg_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_q <= RST_REFERENCE_CONTROL;
        end else if (wr_i && addr_i == ADDR_REFERENCE_CONTROL) begin
            ref_q <= wdata_i & REF_CTRL_IMPL_MASK;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_q <= RST_REGULATOR_CONTROL;
        end else if (wr_i && addr_i == ADDR_REGULATOR_CONTROL) begin
            reg_q <= wdata_i;
        end
    end

    assign cfg.reference_control = ref_q;
    assign cfg.regulator_control = reg_q;
endmodule

// [rtl/arc_top.sv]
// module: analog reference and regulator control, top level
`timescale 1ns/100ps
module arc_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic stop_enter_i,
    input wire logic bias_need_i,
    input wire logic [arc_pkg::NUM_RESET_SRC-1:0] reset_src_i,
    input wire logic reset_pin_i,
    output logic [7:0] sfr_rdata_o,
    output arc_pkg::arc_ref_src_t ref_source_o,
    output logic ref_gain_unity_o,
    output logic temp_sensor_en_o,
    output logic analog_bias_en_o,
    output logic ref_buffer_drive_en_o,
    output logic regulator_on_o,
    output logic stop_active_o,
    output logic reset_req_o
);
    import arc_pkg::*;

    arc_cfg_if cfg_bus ();

    arc_regs u_regs (
        .mclk_i (mclk_i),
        .rst_i (rst_i),
        .wr_i (sfr_wr_i),
        .addr_i (sfr_addr_i),
        .wdata_i (sfr_wdata_i),
        .cfg (cfg_bus.owner)
    );

    logic [7:0] rc;
    logic stop_cfg;
    logic pin_meta_q;
    logic pin_sync_q;
    logic wake_d;
    arc_ref_src_t src_d;

    assign rc = cfg_bus.reference_control;
    assign stop_cfg = cfg_bus.regulator_control[BIT_STOP_POWER_CFG];

    // reset pin synchroniser
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= reset_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // read back
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                ADDR_REFERENCE_CONTROL: sfr_rdata_o <= rc;
                ADDR_REGULATOR_CONTROL:
                    sfr_rdata_o <= cfg_bus.regulator_control;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // reference source selection
    always_comb begin
        if (rc[BIT_REGULATOR_REF_OVERRIDE]) begin
            src_d = ARC_SRC_REGULATOR;
        end else if (rc[BIT_REF_SOURCE_SEL]) begin
            src_d = ARC_SRC_VDD;
        end else begin
            src_d = ARC_SRC_VREF_PIN;
        end
    end

    // analog enables
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_source_o <= ARC_SRC_VREF_PIN;
            ref_gain_unity_o <= 1'b0;
            temp_sensor_en_o <= 1'b0;
            analog_bias_en_o <= 1'b0;
            ref_buffer_drive_en_o <= 1'b0;
        end else begin
            ref_source_o <= src_d;
            ref_gain_unity_o <= rc[BIT_REF_BUFFER_GAIN_SEL];
            temp_sensor_en_o <= rc[BIT_TEMP_SENSOR_EN];
            analog_bias_en_o <= rc[BIT_ANALOG_BIAS_EN]
                | bias_need_i;
            ref_buffer_drive_en_o <= rc[BIT_REF_BUFFER_DRIVE_EN];
        end
    end

    // wake decision: regulator off leaves only the pin
    always_comb begin
        if (stop_active_o && stop_cfg) begin
            wake_d = pin_sync_q;
        end else begin
            wake_d = pin_sync_q | (|reset_src_i);
        end
    end

    // stop state and reset request
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stop_active_o <= 1'b0;
            reset_req_o <= 1'b0;
        end else begin
            reset_req_o <= wake_d;
            if (wake_d) begin
                stop_active_o <= 1'b0;
            end else if (stop_enter_i) begin
                stop_active_o <= 1'b1;
            end
        end
    end

    // regulator power
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            regulator_on_o <= 1'b1;
        end else begin
            regulator_on_o <= !(stop_active_o && stop_cfg && !wake_d) ||
                !stop_active_o && !stop_enter_i;
        end
    end

    a_gain_follows: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ##1 ref_gain_unity_o == $past(rc[BIT_REF_BUFFER_GAIN_SEL]))
        else $error("buffer gain does not follow register");

    a_unused_zero: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == ADDR_REFERENCE_CONTROL
        |=> sfr_rdata_o[6:5] == 2'b00)
        else $error("unused reference bits read nonzero");

    a_unused_store: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rc[6:5] == 2'b00)
        else $error("unused reference bits stored");

    a_override_src: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rc[BIT_REGULATOR_REF_OVERRIDE] |=> ref_source_o == ARC_SRC_REGULATOR)
        else $error("override did not select regulator");

    a_select_src: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rc[BIT_REGULATOR_REF_OVERRIDE] |=> ref_source_o ==
        ($past(rc[BIT_REF_SOURCE_SEL]) ? ARC_SRC_VDD : ARC_SRC_VREF_PIN))
        else $error("reference select mismatch");

    a_temp_enable: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $rose(rc[BIT_TEMP_SENSOR_EN]) |=> temp_sensor_en_o)
        else $error("temperature sensor not enabled");

    a_bias_enable: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rc[BIT_ANALOG_BIAS_EN] && !bias_need_i |=> !analog_bias_en_o)
        else $error("bias on without cause");

    a_bias_auto: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        bias_need_i |=> analog_bias_en_o)
        else $error("bias not forced by peripheral");

    a_buf_drive: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ##1 ref_buffer_drive_en_o == $past(rc[BIT_REF_BUFFER_DRIVE_EN]))
        else $error("buffer drive mismatch");

    a_stop_any_src: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stop_active_o && !stop_cfg && (|reset_src_i) |=> reset_req_o)
        else $error("enabled source failed to reset");

    a_reg_on_stop: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stop_active_o && !stop_cfg |=> regulator_on_o)
        else $error("regulator shut down with stop config clear");

    a_stop_pin_only: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stop_active_o && stop_cfg && !pin_sync_q |=> !reset_req_o)
        else $error("reset escaped with regulator off");

    a_reg_off_stop: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stop_active_o && stop_cfg && !wake_d |=> !regulator_on_o)
        else $error("regulator left on in stop");

    a_reset_clear: assert property (
        @(posedge mclk_i)
        $fell(rst_i) |-> rc == 8'h00 && stop_cfg == 1'b0)
        else $error("registers not cleared by reset");

    c_stop_wake_pin: cover property (@(posedge mclk_i) disable iff (rst_i)
        stop_active_o && stop_cfg ##1 reset_req_o);
    c_stop_wake_src: cover property (@(posedge mclk_i) disable iff (rst_i)
        stop_active_o && !stop_cfg && (|reset_src_i) ##1 reset_req_o);
    c_override: cover property (@(posedge mclk_i) disable iff (rst_i)
        ref_source_o == ARC_SRC_REGULATOR);
    c_vdd: cover property (@(posedge mclk_i) disable iff (rst_i)
        ref_source_o == ARC_SRC_VDD);
    c_reg_off: cover property (@(posedge mclk_i) disable iff (rst_i)
        stop_active_o && !regulator_on_o);
endmodule

// [bench/arc_tb_top.sv]
// testbench: register and power control checks for arc_top
`timescale 1ns/100ps
module arc_tb_top;
    import arc_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic stop_enter_i = 1'b0, bias_need_i = 1'b0, reset_pin_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic [NUM_RESET_SRC-1:0] reset_src_i = '0;
    arc_ref_src_t ref_source_o;
    logic ref_gain_unity_o, temp_sensor_en_o, analog_bias_en_o;
    logic ref_buffer_drive_en_o, regulator_on_o, stop_active_o, reset_req_o;
    int n_errors = 0, n_checks = 0;
    logic [7:0] pat [5] = '{8'hFF, 8'h08, 8'h10, 8'h85, 8'h00};
    arc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .stop_enter_i(stop_enter_i), .bias_need_i(bias_need_i),
        .reset_src_i(reset_src_i), .reset_pin_i(reset_pin_i),
        .sfr_rdata_o(sfr_rdata_o), .ref_source_o(ref_source_o),
        .ref_gain_unity_o(ref_gain_unity_o),
        .temp_sensor_en_o(temp_sensor_en_o),
        .analog_bias_en_o(analog_bias_en_o),
        .ref_buffer_drive_en_o(ref_buffer_drive_en_o),
        .regulator_on_o(regulator_on_o), .stop_active_o(stop_active_o),
        .reset_req_o(reset_req_o));
    always #4 mclk_i = ~mclk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge mclk_i);
        sfr_rd_i = 1'b0;
        @(negedge mclk_i);
        chk(sfr_rdata_o, exp);
    endtask
    task automatic outs(input logic [7:0] d, input logic need);
        logic [7:0] src;
        src = d[4] ? 8'h02 : (d[3] ? 8'h01 : 8'h00);
        repeat (2) @(negedge mclk_i);
        chk(8'(ref_source_o), src);
        chk(8'(ref_gain_unity_o), 8'(d[7]));
        chk(8'(temp_sensor_en_o), 8'(d[2]));
        chk(8'(analog_bias_en_o), 8'(d[1] | need));
        chk(8'(ref_buffer_drive_en_o), 8'(d[0]));
    endtask
    task automatic wait_req(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(negedge mclk_i);
            if (reset_req_o === 1'b1) seen = 1'b1;
        end
        chk(8'(seen), 8'(exp));
    endtask
    task automatic enter_stop();
        stop_enter_i = 1'b1;
        @(negedge mclk_i);
        stop_enter_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        chk(8'(stop_active_o), 8'h01);
    endtask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #16000;
        n_errors++;
        final_report();
    end
    initial begin
        do_reset();
        rd(ADDR_REFERENCE_CONTROL, 8'h00);
        rd(ADDR_REGULATOR_CONTROL, 8'h00);
        chk(8'(regulator_on_o), 8'h01);
        outs(8'h00, 1'b0);
        $display("test reset values done");
        foreach (pat[i]) begin
            wr(ADDR_REFERENCE_CONTROL, pat[i]);
            outs(pat[i], 1'b0);
            rd(ADDR_REFERENCE_CONTROL, pat[i] & 8'h9F);
        end
        bias_need_i = 1'b1;
        outs(8'h00, 1'b1);
        bias_need_i = 1'b0;
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        rd(ADDR_REFERENCE_CONTROL, 8'h00);
        $display("test reference control done");
        wr(ADDR_REGULATOR_CONTROL, 8'h00);
        enter_stop();
        chk(8'(regulator_on_o), 8'h01);
        reset_src_i = '1;
        wait_req(1'b1);
        reset_src_i = '0;
        do_reset();
        $display("test stop with regulator on done");
        wr(ADDR_REGULATOR_CONTROL, 8'h08);
        wr(ADDR_REFERENCE_CONTROL, 8'h9F);
        rd(ADDR_REGULATOR_CONTROL, 8'h08);
        enter_stop();
        @(negedge mclk_i);
        chk(8'(regulator_on_o), 8'h00);
        reset_src_i = '1;
        wait_req(1'b0);
        reset_src_i = '0;
        reset_pin_i = 1'b1;
        wait_req(1'b1);
        chk(8'(stop_active_o), 8'h00);
        reset_pin_i = 1'b0;
        do_reset();
        rd(ADDR_REGULATOR_CONTROL, 8'h00);
        rd(ADDR_REFERENCE_CONTROL, 8'h00);
        $display("test stop with regulator off done");
        final_report();
    end
endmodule
